/* File: rtl/tagbus_defs.vh */
// constants for the disk drive tag/bus command interface
`ifndef TAGBUS_DEFS_VH
`define TAGBUS_DEFS_VH

// apb register byte offsets
`define OFS_CTRL      8'h00
`define OFS_UNIT      8'h04
`define OFS_CYL       8'h08
`define OFS_HEAD      8'h0c
`define OFS_CMD       8'h10
`define OFS_STAT      8'h14
`define OFS_LAST      8'h18

// control register fields
`define CTRL_PWR_BIT  0
`define CTRL_RESET    32'h0000_0001

// status register fields
`define ST_BUSY       0
`define ST_REFUSED    1
`define ST_ON_CYL     2
`define ST_READY      3
`define ST_FAULT      4
`define ST_SEEK_ERR   5
`define ST_SELECTED   6
`define ST_WPROT      7
`define ST_SEEK_END   8
`define ST_DRV_BUSY   9

// field widths
`define BUS_W         10
`define UNIT_W        4
`define HEAD_W        5

// command kinds, one-hot, in tag order
`define K_UNIT        4'b0001
`define K_CYL         4'b0010
`define K_HEAD        4'b0100
`define K_CMD         4'b1000

// timing in ns and derived cycle counts
`define CLK_NS        100
`define SETUP_NS      100
`define STROBE_NS     200
`define HOLD_NS       100
`define NS2CYC(t)     (((t) + `CLK_NS - 1) / `CLK_NS)
`define SETUP_CYC     `NS2CYC(`SETUP_NS)
`define STROBE_CYC    `NS2CYC(`STROBE_NS)
`define HOLD_CYC      `NS2CYC(`HOLD_NS)

`endif

/* File: rtl/tag_sequencer.v */
// setup, strobe and hold sequencer for one tag with its bus value
`timescale 1ns/1ps
`default_nettype none
`include "tagbus_defs.vh"

module tag_sequencer (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              start,
	input  wire [3:0]        kind,
	input  wire [`BUS_W-1:0] value,
	output reg  [3:0]        tag_reg,
	output reg  [`BUS_W-1:0] bus_reg,
	output reg               busy_reg
);

	localparam [3:0] S_IDLE   = 4'b0001;
	localparam [3:0] S_SETUP  = 4'b0010;
	localparam [3:0] S_STROBE = 4'b0100;
	localparam [3:0] S_HOLD   = 4'b1000;
	// cycle counts worked out as integers, then cut to the counter width
	localparam integer SETUP_I  = `SETUP_CYC;
	localparam integer STROBE_I = `STROBE_CYC;
	localparam integer HOLD_I   = `HOLD_CYC;
	localparam [7:0]   SETUP_C  = SETUP_I[7:0];
	localparam [7:0]   STROBE_C = STROBE_I[7:0];
	localparam [7:0]   HOLD_C   = HOLD_I[7:0];

	reg [3:0] state_reg;
	reg [7:0] cnt_reg;
	reg [3:0] kind_reg;

	// state walk: bus first, then tag, then tag off with bus still held
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 8'h00;
			kind_reg  <= 4'h0;
			tag_reg   <= 4'h0;
			bus_reg   <= {`BUS_W{1'b0}};
			busy_reg  <= 1'b0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				if (start) begin
					bus_reg   <= value;
					kind_reg  <= kind;
					cnt_reg   <= SETUP_C - 8'h01;
					busy_reg  <= 1'b1;
					state_reg <= S_SETUP;
				end
			end
			S_SETUP: begin
				if (cnt_reg == 8'h00) begin
					tag_reg   <= kind_reg;
					cnt_reg   <= STROBE_C - 8'h01;
					state_reg <= S_STROBE;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
			S_STROBE: begin
				if (cnt_reg == 8'h00) begin
					tag_reg   <= 4'h0;
					cnt_reg   <= HOLD_C - 8'h01;
					state_reg <= S_HOLD;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
			S_HOLD: begin
				// bus kept until after the strobe is gone
				if (cnt_reg == 8'h00) begin
					busy_reg  <= 1'b0;
					state_reg <= S_IDLE;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
			default: begin
				tag_reg   <= 4'h0;
				busy_reg  <= 1'b0;
				state_reg <= S_IDLE;
			end
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: rtl/tagbus_ctrl.v */
// controller end of the daisy-chained disk drive tag/bus interface
//
// Function
// - controller starts every drive operation except power-on; drive only reports.
// - commands other than selection are a tag strobe with qualifying bus bits.
// - discrete lines each carry one fixed meaning, never qualified by a tag.
// - while powered, controller pulls the power-chain line low for remote power-up.
// - while powered, controller keeps the power-keep line grounded so drives stay powered.
// - controller holds controller-present true while powered on.
// - drive-choose strobe starts selection; dual-channel drives become reserved.
// - drive selected only when unit code bits 0-3 match its address.
// - seek places cylinder on bus bits and pulses the cylinder strobe.
// - cylinder strobe only while the selected drive reports on cylinder.
// - head strobe carries head address on bits 0-4; bits 5-9 unused.
// - control strobe starts operations from bus bits; bit 0 enables writing.
`timescale 1ns/1ps
`default_nettype none
`include "tagbus_defs.vh"

module tagbus_ctrl (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [7:0]        paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output reg               pready,
	output reg               pslverr,
	output wire              unit_strobe,
	output reg  [`UNIT_W-1:0] unit_code,
	output wire              cyl_strobe,
	output wire              head_strobe,
	output wire              ctl_strobe,
	output wire [`BUS_W-1:0] bus_bits,
	output reg               pick_n,
	output reg               hold_n,
	output reg               ctrl_present,
	input  wire              on_cylinder,
	input  wire              unit_ready,
	input  wire              drive_fault,
	input  wire              seek_error,
	input  wire              unit_selected,
	input  wire              write_protected,
	input  wire              seek_end,
	input  wire              drive_busy
);

	reg  [31:0]        ctrl_reg;
	reg                refused_reg;
	reg  [`BUS_W-1:0]  last_cyl_reg;
	reg  [`HEAD_W-1:0] last_head_reg;
	reg                start_reg;
	reg  [3:0]         kind_reg;
	reg  [`BUS_W-1:0]  value_reg;
	reg                start_next;
	reg  [3:0]         kind_next;
	reg  [`BUS_W-1:0]  value_next;
	reg                refuse_next;
	reg  [31:0]        rdata_next;
	reg                err_next;
	wire [3:0]         tag_w;
	wire               seq_busy;
	wire               wr_access;
	wire               rd_setup;
	wire               busy_any;

	// address match for one register word
	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// any defined register offset
	function mapped;
		input [7:0] a;
		begin
			mapped = hit(a, `OFS_CTRL) | hit(a, `OFS_UNIT) | hit(a, `OFS_CYL) |
			         hit(a, `OFS_HEAD) | hit(a, `OFS_CMD)  | hit(a, `OFS_STAT) |
			         hit(a, `OFS_LAST);
		end
	endfunction

	// write lands in the access cycle, read data is built in setup
	assign wr_access = psel & penable & pready & pwrite;
	assign rd_setup  = psel & ~penable;
	// a launched command counts as busy until the sequencer picks it up
	assign busy_any  = seq_busy | start_reg;

	// apb handshake: no wait states, answer flops loaded in setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup & err_next;
			if (rd_setup) begin
				prdata <= rdata_next;
			end
		end
	end

	// read mux and unmapped address answer
	always @* begin
		rdata_next = 32'h0000_0000;
		err_next   = ~mapped(paddr);
		if (!pwrite) begin
			if (hit(paddr, `OFS_CTRL)) begin
				rdata_next = ctrl_reg;
			end else if (hit(paddr, `OFS_UNIT)) begin
				rdata_next = {28'h000_0000, unit_code};
			end else if (hit(paddr, `OFS_CYL)) begin
				rdata_next = {22'h00_0000, last_cyl_reg};
			end else if (hit(paddr, `OFS_HEAD)) begin
				rdata_next = {27'h000_0000, last_head_reg};
			end else if (hit(paddr, `OFS_STAT)) begin
				// each drive line reported on its own bit
				rdata_next[`ST_BUSY]     = busy_any;
				rdata_next[`ST_REFUSED]  = refused_reg;
				rdata_next[`ST_ON_CYL]   = on_cylinder;
				rdata_next[`ST_READY]    = unit_ready;
				rdata_next[`ST_FAULT]    = drive_fault;
				rdata_next[`ST_SEEK_ERR] = seek_error;
				rdata_next[`ST_SELECTED] = unit_selected;
				rdata_next[`ST_WPROT]    = write_protected;
				rdata_next[`ST_SEEK_END] = seek_end;
				rdata_next[`ST_DRV_BUSY] = drive_busy;
			end else if (hit(paddr, `OFS_LAST)) begin
				rdata_next = {17'h0_0000, last_head_reg, last_cyl_reg};
			end
		end
	end

	// command launch decision for a register write
	always @* begin
		start_next  = 1'b0;
		kind_next   = 4'h0;
		value_next  = {`BUS_W{1'b0}};
		refuse_next = 1'b0;
		if (wr_access) begin
			if (hit(paddr, `OFS_UNIT)) begin
				// unit code on its own lines with the choose strobe
				if (busy_any) begin
					refuse_next = 1'b1;
				end else begin
					start_next = 1'b1;
					kind_next  = `K_UNIT;
				end
			end else if (hit(paddr, `OFS_CYL)) begin
				// seek only when the selected drive is on cylinder
				if (busy_any | ~unit_selected | ~on_cylinder) begin
					refuse_next = 1'b1;
				end else begin
					// cylinder address onto the bus bits
					start_next = 1'b1;
					kind_next  = `K_CYL;
					value_next = pwdata[`BUS_W-1:0];
				end
			end else if (hit(paddr, `OFS_HEAD)) begin
				if (busy_any | ~unit_selected) begin
					refuse_next = 1'b1;
				end else begin
					// head address on bits 0-4, upper bits driven low
					start_next = 1'b1;
					kind_next  = `K_HEAD;
					value_next = {{(`BUS_W-`HEAD_W){1'b0}}, pwdata[`HEAD_W-1:0]};
				end
			end else if (hit(paddr, `OFS_CMD)) begin
				if (busy_any | ~unit_selected) begin
					refuse_next = 1'b1;
				end else begin
					// control bits passed as written, bit 0 gates writing
					start_next = 1'b1;
					kind_next  = `K_CMD;
					value_next = pwdata[`BUS_W-1:0];
				end
			end
		end
	end

	// software registers and command hand-off
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg      <= `CTRL_RESET;
			refused_reg   <= 1'b0;
			unit_code     <= {`UNIT_W{1'b0}};
			last_cyl_reg  <= {`BUS_W{1'b0}};
			last_head_reg <= {`HEAD_W{1'b0}};
			start_reg     <= 1'b0;
			kind_reg      <= 4'h0;
			value_reg     <= {`BUS_W{1'b0}};
		end else begin
			// drive activity only ever starts from a software write
			start_reg <= start_next;
			if (start_next) begin
				kind_reg  <= kind_next;
				value_reg <= value_next;
			end
			if (wr_access && hit(paddr, `OFS_CTRL)) begin
				ctrl_reg <= {31'h0000_0000, pwdata[`CTRL_PWR_BIT]};
			end
			if (start_next && kind_next == `K_UNIT) begin
				unit_code <= pwdata[`UNIT_W-1:0];
			end
			if (start_next && kind_next == `K_CYL) begin
				last_cyl_reg <= value_next;
			end
			if (start_next && kind_next == `K_HEAD) begin
				last_head_reg <= pwdata[`HEAD_W-1:0];
			end
			// sticky refusal, a new refusal wins over a clear
			if (refuse_next) begin
				refused_reg <= 1'b1;
			end else if (wr_access && hit(paddr, `OFS_STAT) && pwdata[`ST_REFUSED]) begin
				refused_reg <= 1'b0;
			end
		end
	end

	// power sequencing and presence lines
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pick_n       <= 1'b1;
			hold_n       <= 1'b1;
			ctrl_present <= 1'b0;
		end else begin
			// power-chain line low while power is enabled
			pick_n       <= ~ctrl_reg[`CTRL_PWR_BIT];
			hold_n       <= ~ctrl_reg[`CTRL_PWR_BIT];
			// present asserted whenever out of reset
			ctrl_present <= 1'b1;
		end
	end

	// strobe timing and bus hold
	tag_sequencer u_seq (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (start_reg),
		.kind     (kind_reg),
		.value    (value_reg),
		.tag_reg  (tag_w),
		.bus_reg  (bus_bits),
		.busy_reg (seq_busy)
	);

	assign unit_strobe = tag_w[0];
	assign cyl_strobe  = tag_w[1];
	assign head_strobe = tag_w[2];
	assign ctl_strobe  = tag_w[3];

endmodule
`default_nettype wire

/* File: test/tagbus_monitor.sv */
// assertion checker on the controller's pins
`timescale 1ns/1ps
`default_nettype none
`include "tagbus_defs.vh"
module tagbus_monitor (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              unit_strobe,
	input wire logic [`UNIT_W-1:0] unit_code,
	input wire logic              cyl_strobe,
	input wire logic              head_strobe,
	input wire logic              ctl_strobe,
	input wire logic [`BUS_W-1:0] bus_bits,
	input wire logic              pick_n,
	input wire logic              hold_n,
	input wire logic              ctrl_present,
	input wire logic              on_cylinder
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// any tag high, completed write, power write
	wire logic any_s = unit_strobe | cyl_strobe | head_strobe | ctl_strobe;
	wire logic acc_w = psel && penable && pready && pwrite;
	wire logic ctrl_w = acc_w && (paddr == `OFS_CTRL);
	sequence s_pulse; any_s ##1 !any_s; endsequence
	sequence s_cause; $past(acc_w, 2) || $past(acc_w, 3) || $past(acc_w, 4); endsequence
	property p_present; $past(presetn) |-> ctrl_present; endproperty
	property p_pick; ctrl_w && pwdata[0] |-> ##[1:2] (!pick_n && !hold_n); endproperty
	property p_ready; psel && !penable |=> pready && psel && penable; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_width; $rose(any_s) |=> s_pulse; endproperty
	property p_origin; $rose(any_s) |-> s_cause; endproperty
	property p_onehot; $onehot0({unit_strobe, cyl_strobe, head_strobe, ctl_strobe}); endproperty
	property p_stable; any_s || $past(any_s) |-> $stable(bus_bits); endproperty
	property p_oncyl; $rose(cyl_strobe) |-> on_cylinder; endproperty
	property p_head; head_strobe |-> bus_bits[9:5] == 5'h00; endproperty
	property p_code; unit_strobe |-> $stable(unit_code); endproperty
	a_present: assert property (p_present) else $error("present line low");
	a_pick: assert property (p_pick) else $error("power lines not low");
	a_ready: assert property (p_ready) else $error("no ready in access");
	a_err: assert property (p_err) else $error("error without ready");
	a_width: assert property (p_width) else $error("strobe not two cycles");
	a_origin: assert property (p_origin) else $error("strobe without write");
	a_onehot: assert property (p_onehot) else $error("two tags at once");
	a_stable: assert property (p_stable) else $error("bus moved in strobe");
	a_oncyl: assert property (p_oncyl) else $error("seek while moving");
	a_head: assert property (p_head) else $error("head high bits set");
	a_code: assert property (p_code) else $error("unit code moved");
endmodule
bind tagbus_ctrl tagbus_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .unit_strobe(unit_strobe), .unit_code(unit_code),
	.cyl_strobe(cyl_strobe), .head_strobe(head_strobe), .ctl_strobe(ctl_strobe),
	.bus_bits(bus_bits), .pick_n(pick_n), .hold_n(hold_n), .ctrl_present(ctrl_present),
	.on_cylinder(on_cylinder));
`default_nettype wire

/* File: test/drive_model.sv */
// behavioural disk drive on the far side of the tag/bus cable
`timescale 1ns/1ps
`default_nettype none
module drive_model #(parameter logic [3:0] ADDR = 4'h3) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        unit_strobe,
	input wire logic [3:0]  unit_code,
	input wire logic        cyl_strobe,
	input wire logic        pick_n,
	input wire logic        hold_n,
	input wire logic        ctrl_present,
	output logic            on_cylinder,
	output logic            unit_ready,
	output logic            drive_fault,
	output logic            seek_error,
	output logic            unit_selected,
	output logic            write_protected,
	output logic            seek_end,
	output logic            drive_busy
);
	logic       sel_reg;
	logic [5:0] seek_reg;
	// select on match, seek on strobe
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= 1'b0;
			seek_reg <= 6'h00;
		end else begin
			if (unit_strobe) sel_reg <= ctrl_present && (unit_code == ADDR);
			if (cyl_strobe && sel_reg) seek_reg <= 6'h28;
			else if (seek_reg != 6'h00) seek_reg <= seek_reg - 6'h01;
		end
	end
	// each status line one meaning, ready once selected and powered
	assign unit_selected = sel_reg;
	assign on_cylinder = sel_reg && (seek_reg == 6'h00);
	assign seek_end = on_cylinder;
	assign unit_ready = sel_reg && !pick_n && !hold_n;
	assign drive_fault = 1'b0;
	assign seek_error = 1'b0;
	// selected unit reports write protect, busy while its heads move
	assign write_protected = sel_reg;
	assign drive_busy = sel_reg && (seek_reg != 6'h00);
endmodule
`default_nettype wire

/* File: test/tagbus_ctrl_tb.sv */
// self-checking bench for the tag/bus controller
`timescale 1ns/1ps
`default_nettype none
`include "tagbus_defs.vh"
module tagbus_ctrl_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pick_n, hold_n, ctrl_present;
	logic unit_strobe, cyl_strobe, head_strobe, ctl_strobe, on_cylinder, unit_ready;
	logic drive_fault, seek_error, unit_selected, write_protected, seek_end, drive_busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] unit_code, tg_d;
	logic [9:0] bus_bits, c, h;
	logic [15:0] lf;
	logic [33:0] rq[$];
	logic [17:0] sq[$];
	int n_fail, n_tests;
	wire logic [3:0] tg = {ctl_strobe, head_strobe, cyl_strobe, unit_strobe};
	tagbus_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .unit_strobe(unit_strobe), .unit_code(unit_code),
		.cyl_strobe(cyl_strobe), .head_strobe(head_strobe), .ctl_strobe(ctl_strobe),
		.bus_bits(bus_bits), .pick_n(pick_n), .hold_n(hold_n), .ctrl_present(ctrl_present),
		.on_cylinder(on_cylinder), .unit_ready(unit_ready), .drive_fault(drive_fault),
		.seek_error(seek_error), .unit_selected(unit_selected),
		.write_protected(write_protected), .seek_end(seek_end), .drive_busy(drive_busy));
	drive_model drv (.pclk(pclk), .presetn(presetn), .unit_strobe(unit_strobe),
		.unit_code(unit_code), .cyl_strobe(cyl_strobe), .pick_n(pick_n), .hold_n(hold_n),
		.ctrl_present(ctrl_present), .on_cylinder(on_cylinder), .unit_ready(unit_ready),
		.drive_fault(drive_fault), .seek_error(seek_error), .unit_selected(unit_selected),
		.write_protected(write_protected), .seek_end(seek_end), .drive_busy(drive_busy));
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) chk("pready", 33'h1, {32'h0, pready});
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// expected read: bit 33 ignores the data, bit 32 is the error
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic cmd(input logic [7:0] a, input logic [31:0] d, input logic [17:0] e);
		if (e != 18'h0) sq.push_back(e);
		apb(a, 1'b1, d);
		repeat (8) @(posedge pclk);
	endtask
	task end_sim;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// read results against the oldest note
	always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) begin
		if (rq.size() == 0) chk("rd_extra", 33'h0, 33'h1);
		else chk("prdata", rq[0][32:0], {pslverr, rq[0][33] ? rq[0][31:0] : prdata});
		if (rq.size() != 0) void'(rq.pop_front());
	end
	// tag rises against the oldest note
	always @(posedge pclk) begin
		tg_d <= tg;
		if (tg != 4'h0 && tg_d == 4'h0) begin
			if (sq.size() == 0) chk("tag_extra", 33'h0, 33'h1);
			else chk("tag", sq.pop_front(), {tg, unit_code, bus_bits});
		end
	end
	initial begin
		#(100 * 5000);
		n_fail++;
		end_sim;
	end
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; lf = 16'h0028;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`OFS_CTRL, {2'b00, `CTRL_RESET});
		rd(`OFS_STAT, 34'h0);
		rd(`OFS_LAST, 34'h0);
		rd(8'h1c, {2'b11, 32'h0});
		chk("power", 33'h0, {ctrl_present !== 1'b1, pick_n, hold_n});
		$display("test reset done");
		cmd(`OFS_UNIT, 32'h3, {4'b0001, 4'h3, 10'h0});
		rd(`OFS_STAT, 34'h1cc);
		lf = nxt(lf); c = lf[9:0];
		cmd(`OFS_CYL, {22'h0, c}, {4'b0010, 4'h3, c});
		cmd(`OFS_CYL, 32'h1, 18'h0);
		rd(`OFS_STAT, 34'h2ca);
		apb(`OFS_STAT, 1'b1, 32'h2);
		repeat (40) @(posedge pclk);
		rd(`OFS_STAT, 34'h1cc);
		$display("test seek done");
		lf = nxt(lf); h = lf[9:0];
		cmd(`OFS_HEAD, {22'h0, h}, {4'b0100, 4'h3, 5'h00, h[4:0]});
		for (int i = 0; i < 10; i++) cmd(`OFS_CMD, 32'h1 << i, {4'b1000, 4'h3, 10'h1 << i});
		rd(`OFS_LAST, {17'h0, h[4:0], c});
		$display("test head control done");
		cmd(`OFS_UNIT, 32'h5, {4'b0001, 4'h5, 10'h0});
		cmd(`OFS_CYL, 32'h7, 18'h0);
		rd(`OFS_STAT, 34'h002);
		apb(`OFS_STAT, 1'b1, 32'h2);
		$display("test wrong unit done");
		apb(`OFS_CTRL, 1'b1, 32'h0);
		repeat (2) @(posedge pclk);
		chk("pwr_off", 33'h3, {pick_n, hold_n});
		apb(`OFS_CTRL, 1'b1, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("in_reset", 33'h3, {ctrl_present, pick_n, hold_n});
		presetn <= 1'b1;
		rd(`OFS_STAT, 34'h0);
		rd(`OFS_CTRL, {2'b00, `CTRL_RESET});
		repeat (2) @(posedge pclk);
		chk("queues", 33'h0, rq.size() + sq.size());
		$display("test mid reset done");
		end_sim;
	end
endmodule
`default_nettype wire
